// [rtl/ptb_chain.sv]
// Prescaler, 15-stage counter chain and tap event detect
`timescale 1ns/10ps
module ptb_chain (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Control and result
    ptb_cnt_if.chain cb
);
    import ptb_pkg::*;

    logic [PRE_W-1:0] pre_reg;
    logic [STAGES-1:0] count_reg;
    logic roll_reg;
    logic adv;
    logic [STAGES-1:0] count_next;
    logic [TAP_W-1:0] tap;

    //--------------------------------------------------------------------------
    // Chain advance
    //--------------------------------------------------------------------------

    // Advance on every rising reference edge, or every 128th when prescaled
    assign adv = cb.tick && (!cb.src_div128 || (pre_reg == PRE_LAST));
    assign count_next = count_reg + 15'h0001;
    assign tap = ptb_tap_bit(cb.rate_sel);

    // Prescaler, cleared with the chain
    always_ff @(posedge clk_i) begin
        if (rst_i || !cb.run) begin
            pre_reg <= 7'h00;
        end else if (cb.tick) begin
            pre_reg <= pre_reg + 7'h01;
        end
    end

    // Fifteen stage counter, held at zero while stopped
    always_ff @(posedge clk_i) begin
        if (rst_i || !cb.run) begin
            count_reg <= 15'h0000;
        end else if (adv) begin
            count_reg <= count_next;
        end
    end

    // Event on the rise of the tap bit: first at half period, then every period
    always_ff @(posedge clk_i) begin
        if (rst_i || !cb.run) begin
            roll_reg <= 1'b0;
        end else begin
            roll_reg <= adv && !count_reg[tap] && count_next[tap];
        end
    end

    assign cb.count = count_reg;
    assign cb.rollover = roll_reg;

endmodule // ptb_chain

// [rtl/ptb_cnt_if.sv]
// Interface between the timebase register block and its counter chain
`timescale 1ns/10ps
interface ptb_cnt_if;
    logic run;
    logic src_div128;
    logic [2:0] rate_sel;
    logic tick;
    logic [14:0] count;
    logic rollover;

    modport ctl (output run, output src_div128, output rate_sel, output tick,
                 input count, input rollover);
    modport chain (input run, input src_div128, input rate_sel, input tick,
                   output count, output rollover);
endinterface

// [rtl/ptb_pkg.sv]
// Constants, register map and tap decode for the periodic timebase
//------------------------------------------------------------------------------
//------------------------------------------------------------------------------
package ptb_pkg;

    // Chain geometry
    localparam int STAGES = 15;
    localparam int PRE_W = 7;
    localparam logic [6:0] PRE_LAST = 7'h7f;
    localparam int TAP_W = 4;

    // Register byte offsets
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_CFG = 4'h4;
    localparam logic [3:0] OFS_EVT = 4'h8;
    localparam logic [3:0] OFS_MASK = 4'hc;

    // Control register fields
    localparam int CTRL_RUN = 0;
    localparam int CTRL_RATE_LO = 1;
    localparam int CTRL_IE = 4;
    localparam int CTRL_ACK = 5;
    localparam int CTRL_FLAG = 7;

    // Configuration register fields
    localparam int CFG_DIV128 = 0;
    localparam int CFG_STOPRUN = 1;

    // Event status and mask fields
    localparam int EVT_W = 2;
    localparam int EVT_PERIOD = 0;
    localparam int EVT_OVERRUN = 1;

    // Reset values
    localparam logic [2:0] RATE_RST = 3'h0;
    localparam logic [1:0] EVT_RST = 2'h0;

    // Chain bit index whose rising edge marks an event for a rate code
    function automatic logic [3:0] ptb_tap_bit(input logic [2:0] sel);
        logic [3:0] idx;
        idx = 4'he;
        case (sel)
            3'h0: idx = 4'he;
            3'h1: idx = 4'hc;
            3'h2: idx = 4'ha;
            3'h3: idx = 4'h6;
            3'h4: idx = 4'h5;
            3'h5: idx = 4'h4;
            3'h6: idx = 4'h3;
            3'h7: idx = 4'h2;
            default: idx = 4'he;
        endcase
        return idx;
    endfunction

    // Low-bit mask up to and including the tap bit
    function automatic logic [14:0] ptb_tap_mask(input logic [2:0] sel);
        logic [15:0] one_hot;
        one_hot = 16'h0001 << ptb_tap_bit(sel);
        return 15'((one_hot << 1) - 16'h0001);
    endfunction

endpackage

// [rtl/ptb_timebase.sv]
// Periodic timebase with Wishbone registers, interrupt and stop wakeup
//
// Our own choices: the placing of the registers and the Wishbone slave port.
`timescale 1ns/10ps
module ptb_timebase (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Reference clock pin and stop state
    input wire logic ext_ref_clock_i,
    input wire logic stop_i,
    // Interrupt and wakeup
    output logic irq_o,
    output logic wake_o
);
    import ptb_pkg::*;

    ptb_cnt_if cb ();

    //--------------------------------------------------------------------------
    // Declarations
    //--------------------------------------------------------------------------

    logic ref_s1_reg;
    logic ref_s2_reg;
    logic ref_s3_reg;
    logic ref_lvl_reg;
    logic tick_reg;
    logic run_reg;
    logic [2:0] rate_select_reg;
    logic period_irq_enable_reg;
    logic period_flag_reg;
    logic src_div128_reg;
    logic osc_run_in_stop_reg;
    logic [EVT_W-1:0] evt_reg;
    logic [EVT_W-1:0] mask_reg;
    logic ack_reg;
    logic [31:0] dat_reg;
    logic irq_reg;
    logic wake_reg;
    logic req;
    logic wr_lo;
    logic rd;
    logic ack_wr;
    logic count_ok;
    logic [EVT_W-1:0] evt_set;
    logic [31:0] rd_next;

    //--------------------------------------------------------------------------
    // Bus decode
    //--------------------------------------------------------------------------

    // New request is taken in the cycle before the ack
    assign req = wb_cyc_i && wb_stb_i && !ack_reg;
    assign wr_lo = req && wb_we_i && wb_sel_i[0];
    assign rd = req && !wb_we_i;
    assign ack_wr = wr_lo && (wb_adr_i == OFS_CTRL) && wb_dat_i[CTRL_ACK];

    // Ack one cycle after the request, dropped the next cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= req;
        end
    end

    //--------------------------------------------------------------------------
    // Reference clock synchroniser
    //--------------------------------------------------------------------------

    // Three stage capture of the pin
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ref_s1_reg <= 1'b0;
            ref_s2_reg <= 1'b0;
            ref_s3_reg <= 1'b0;
        end else begin
            ref_s1_reg <= ext_ref_clock_i;
            ref_s2_reg <= ref_s1_reg;
            ref_s3_reg <= ref_s2_reg;
        end
    end

    // Accepted level changes only when the two later stages agree
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ref_lvl_reg <= 1'b0;
            tick_reg <= 1'b0;
        end else begin
            if (ref_s2_reg == ref_s3_reg) begin
                ref_lvl_reg <= ref_s3_reg;
            end
            tick_reg <= (ref_s2_reg == ref_s3_reg) && ref_s3_reg && !ref_lvl_reg
                && count_ok;
        end
    end

    // Counting allowed when running, and in stop only with the oscillator kept on
    assign count_ok = !stop_i || osc_run_in_stop_reg;

    //--------------------------------------------------------------------------
    // Control and configuration registers
    //--------------------------------------------------------------------------

    // Run, rate select and interrupt enable
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            run_reg <= 1'b0;
            rate_select_reg <= RATE_RST;
            period_irq_enable_reg <= 1'b0;
        end else if (wr_lo && (wb_adr_i == OFS_CTRL)) begin
            run_reg <= wb_dat_i[CTRL_RUN];
            rate_select_reg <= wb_dat_i[CTRL_RATE_LO +: 3];
            period_irq_enable_reg <= wb_dat_i[CTRL_IE];
        end
    end

    // Clock source and stop behaviour options
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            src_div128_reg <= 1'b0;
            osc_run_in_stop_reg <= 1'b0;
        end else if (wr_lo && (wb_adr_i == OFS_CFG)) begin
            src_div128_reg <= wb_dat_i[CFG_DIV128];
            osc_run_in_stop_reg <= wb_dat_i[CFG_STOPRUN];
        end
    end

    // Event mask register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mask_reg <= EVT_RST;
        end else if (wr_lo && (wb_adr_i == OFS_MASK)) begin
            mask_reg <= wb_dat_i[EVT_W-1:0];
        end
    end

    //--------------------------------------------------------------------------
    // Counter chain
    //--------------------------------------------------------------------------

    assign cb.run = run_reg;
    assign cb.src_div128 = src_div128_reg;
    assign cb.rate_sel = rate_select_reg;
    assign cb.tick = tick_reg;

    ptb_chain u_chain (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .cb(cb)
    );

    //--------------------------------------------------------------------------
    // Period flag and event status
    //--------------------------------------------------------------------------

    // Period flag: a rollover wins over an acknowledge in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            period_flag_reg <= 1'b0;
        end else if (cb.rollover) begin
            period_flag_reg <= 1'b1;
        end else if (ack_wr) begin
            period_flag_reg <= 1'b0;
        end
    end

    // Sticky events: period seen, and period seen while flag still pending
    assign evt_set[EVT_PERIOD] = cb.rollover;
    assign evt_set[EVT_OVERRUN] = cb.rollover && period_flag_reg && !ack_wr;

    // Read of the status clears it, a new event in the same cycle survives
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            evt_reg <= EVT_RST;
        end else if (rd && (wb_adr_i == OFS_EVT)) begin
            evt_reg <= evt_set;
        end else begin
            evt_reg <= evt_reg | evt_set;
        end
    end

    //--------------------------------------------------------------------------
    // Read data
    //--------------------------------------------------------------------------

    // Read mux; ack bit and unmapped offsets read zero
    always_comb begin
        rd_next = 32'h0000_0000;
        case (wb_adr_i)
            OFS_CTRL: begin
                rd_next[CTRL_RUN] = run_reg;
                rd_next[CTRL_RATE_LO +: 3] = rate_select_reg;
                rd_next[CTRL_IE] = period_irq_enable_reg;
                rd_next[CTRL_ACK] = 1'b0;
                rd_next[CTRL_FLAG] = period_flag_reg;
            end
            OFS_CFG: begin
                rd_next[CFG_DIV128] = src_div128_reg;
                rd_next[CFG_STOPRUN] = osc_run_in_stop_reg;
            end
            OFS_EVT: begin
                rd_next[EVT_W-1:0] = evt_reg;
            end
            OFS_MASK: begin
                rd_next[EVT_W-1:0] = mask_reg;
            end
            default: begin
                rd_next = 32'h0000_0000;
            end
        endcase
    end

    // Data register, loaded with the answer and zero otherwise
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_reg <= 32'h0000_0000;
        end else if (rd) begin
            dat_reg <= rd_next;
        end else begin
            dat_reg <= 32'h0000_0000;
        end
    end

    //--------------------------------------------------------------------------
    // Interrupt and wakeup
    //--------------------------------------------------------------------------

    // Level interrupt from the flag and from unmasked sticky events
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= (period_flag_reg && period_irq_enable_reg) || |(evt_reg & mask_reg);
        end
    end

    // Wakeup pulse for each period event taken while in stop
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wake_reg <= 1'b0;
        end else begin
            wake_reg <= cb.rollover && stop_i;
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = dat_reg;
    assign irq_o = irq_reg;
    assign wake_o = wake_reg;

    //--------------------------------------------------------------------------
    // Assertions
    //--------------------------------------------------------------------------

    default clocking dc @(posedge clk_i); endclocking
    default disable iff (rst_i);

    counter_cleared_a: assert property (!run_reg |=> cb.count == 15'h0000)
        else $error("counter not zero while stopped");

    tap_rise_a: assert property (cb.rollover |->
        cb.count[ptb_tap_bit($past(rate_select_reg))]
        && !$past(cb.count[ptb_tap_bit(rate_select_reg)]))
        else $error("rollover not at the selected tap");

    half_period_a: assert property (cb.rollover && $stable(rate_select_reg) |->
        (cb.count & ptb_tap_mask(rate_select_reg))
        == 15'(ptb_tap_mask(rate_select_reg) ^ (ptb_tap_mask(rate_select_reg) >> 1)))
        else $error("event not on half-period phase");

    flag_set_a: assert property (cb.rollover |=> period_flag_reg)
        else $error("rollover did not set the period flag");

    irq_follows_a: assert property (period_flag_reg && period_irq_enable_reg |=> irq_o)
        else $error("interrupt missing while flag enabled");

    ack_clears_a: assert property (ack_wr && !cb.rollover |=> !period_flag_reg)
        else $error("ack did not clear the period flag");

    zero_ack_a: assert property (wr_lo && wb_adr_i == OFS_CTRL && !wb_dat_i[CTRL_ACK]
        && !period_flag_reg && !cb.rollover |=> !period_flag_reg ##1 wb_dat_o[CTRL_ACK] == 1'b0)
        else $error("ack bit zero write changed state");

    stop_hold_a: assert property (stop_i && !osc_run_in_stop_reg |=> !tick_reg)
        else $error("chain advanced in stop without oscillator");

    prescale_a: assert property (src_div128_reg && $stable(src_div128_reg) && run_reg
        && $past(run_reg) && $changed(cb.count) |-> $past(u_chain.pre_reg) == PRE_LAST)
        else $error("prescaled chain advanced early");

    roll_seen_c: cover property (cb.rollover);
    irq_rise_c: cover property ($rose(irq_o));
    wake_seen_c: cover property (wake_o);
    overrun_c: cover property (evt_reg[EVT_OVERRUN]);

endmodule // ptb_timebase

// [verif/ptb_refgen.sv]
// Reference clock source model that drives the timebase reference pin
`timescale 1ns/10ps
module ptb_refgen (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Control
    input wire logic en_i,
    input wire logic [7:0] half_i,
    // Reference pin and rising edge count
    output logic ref_o,
    output logic [31:0] edge_cnt_o
);
    logic [7:0] div_reg;

    //--------------------------------------------------------------------------
    // Pin generator
    //--------------------------------------------------------------------------
    // Toggles every half_i clocks while enabled, stands low otherwise
    always_ff @(posedge clk_i) begin
        if (rst_i || !en_i) begin
            div_reg <= 8'h00;
            ref_o <= 1'b0;
            edge_cnt_o <= 32'h0;
        end else if (div_reg == half_i - 8'h01) begin
            div_reg <= 8'h00;
            ref_o <= !ref_o;
            edge_cnt_o <= edge_cnt_o + {31'h0, !ref_o}; // Count rising edges only
        end else begin
            div_reg <= div_reg + 8'h01;
        end
    end
endmodule // ptb_refgen

// [verif/tb_top.sv]
// Self-checking testbench for the periodic timebase
`timescale 1ns/10ps
module tb_top;
    import ptb_pkg::*;
    typedef struct {logic [3:0] adr; logic [31:0] wd; logic [31:0] ex;} ptb_row_t;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, stop = 1'b0, ref_en = 1'b0;
    logic [3:0] adr = 4'h0, sel = 4'h0;
    logic [31:0] dw = 32'h0, dr, edge_cnt, q, w0, i0, n_wake = 32'h0, n_irq = 32'h0;
    logic ack, ext, irq_o, wake;
    int n_fail = 0;
    int n_checks = 0;
    ptb_row_t rows [10] = '{'{4'h0, 32'h3e, 32'h1e}, '{4'h0, 32'ha0, 32'h0},
        '{4'h0, 32'hffffff0e, 32'h0e}, '{4'h0, 32'h02, 32'h02}, '{4'h4, 32'hff, 32'h03},
        '{4'h4, 32'h0, 32'h0}, '{4'hc, 32'hff, 32'h03}, '{4'hc, 32'h0, 32'h0},
        '{4'h2, 32'hff, 32'h0}, '{4'h6, 32'hff, 32'h0}};
    logic [31:0] ratio_tbl [8] = '{32'h8000, 32'h2000, 32'h800, 32'h80, 32'h40, 32'h20,
        32'h10, 32'h8};

    //--------------------------------------------------------------------------
    // Clock, design and partner
    //--------------------------------------------------------------------------
    always #5 clk_i = ~clk_i;
    ptb_timebase dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dw), .wb_dat_o(dr),
        .wb_ack_o(ack), .ext_ref_clock_i(ext), .stop_i(stop), .irq_o(irq_o),
        .wake_o(wake));
    ptb_refgen ref_u (.clk_i(clk_i), .rst_i(rst_i), .en_i(ref_en), .half_i(8'h05),
        .ref_o(ext), .edge_cnt_o(edge_cnt));
    // Pulse and level tallies
    always @(posedge clk_i) begin
        n_wake <= n_wake + {31'h0, wake === 1'b1};
        n_irq <= n_irq + {31'h0, irq_o === 1'b1};
    end

    //--------------------------------------------------------------------------
    // Bus cycles and compares
    //--------------------------------------------------------------------------
    task automatic wb_xfer(input logic w, input logic [3:0] a, input logic [3:0] s,
                           input logic [31:0] d, output logic [31:0] r);
        int k;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= s;
        dw <= d;
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (ack !== 1'b1 && k < 50);
        r = dr;
        if (k >= 50) n_fail++;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        chk_val({31'h0, got}, {31'h0, exp});
    endtask
    task automatic wait_irq(input logic lvl, input int lim);
        int k;
        k = 0;
        while (irq_o !== lvl && k < lim) begin
            @(posedge clk_i);
            k++;
        end
        if (k >= lim) chk_bit(irq_o, lvl);
    endtask
    task automatic wait_edges(input logic [31:0] n);
        int k;
        k = 0;
        while (edge_cnt < n && k < 5000) begin
            @(posedge clk_i);
            k++;
        end
        repeat (10) @(posedge clk_i);
    endtask
    function automatic logic [31:0] ctrl_w(logic run, logic [2:0] r, logic ie, logic a);
        return {26'h0, a, ie, r, run};
    endfunction
    // Fresh start: pin stopped, flag cleared, counter held then released
    task automatic restart(input logic [2:0] r, input logic ie);
        ref_en <= 1'b0;
        wb_xfer(1'b1, OFS_CTRL, 4'h1, 32'h20, q);
        wb_xfer(1'b0, OFS_EVT, 4'h1, 32'h0, q);
        wb_xfer(1'b1, OFS_CTRL, 4'h1, ctrl_w(1'b1, r, ie, 1'b0), q);
        w0 = n_wake;
        i0 = n_irq;
        ref_en <= 1'b1;
    endtask
    task automatic period_test(input logic [2:0] r, input logic dv, input logic [31:0] per);
        logic [31:0] e1;
        wb_xfer(1'b1, OFS_CFG, 4'h1, {31'h0, dv}, q);
        restart(r, 1'b1);
        wait_irq(1'b1, per * 12 + 100);
        chk_val(edge_cnt, per >> 1);
        e1 = edge_cnt;
        wb_xfer(1'b1, OFS_CTRL, 4'h1, ctrl_w(1'b1, r, 1'b1, 1'b0), q);
        chk_bit(irq_o, 1'b1);
        wb_xfer(1'b1, OFS_CTRL, 4'h1, ctrl_w(1'b1, r, 1'b1, 1'b1), q);
        wait_irq(1'b0, 10);
        wait_irq(1'b1, per * 12 + 100);
        chk_val(edge_cnt - e1, per);
    endtask
    task automatic tally_and_finish;
        $display("checks=%0d mismatches=%0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    //--------------------------------------------------------------------------
    // Main sequence
    //--------------------------------------------------------------------------
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            wb_xfer(1'b0, 4'(i * 4), 4'h1, 32'h0, q);
            chk_val(q, 32'h0);
        end
        chk_bit(irq_o, 1'b0);
        // Register rows: write, then read back
        foreach (rows[i]) begin
            wb_xfer(1'b1, rows[i].adr, 4'hf, rows[i].wd, q);
            wb_xfer(1'b0, rows[i].adr, 4'hf, 32'h0, q);
            chk_val(q, rows[i].ex);
        end
        // Byte lane zero disabled: write ignored
        wb_xfer(1'b1, OFS_CFG, 4'he, 32'h3, q);
        wb_xfer(1'b0, OFS_CFG, 4'hf, 32'h0, q);
        chk_val(q, 32'h0);
        // Every tap from code 2 to 7, then the extra divide-by-128 source
        for (int c = 2; c < 8; c++) period_test(3'(c), 1'b0, ratio_tbl[c]);
        period_test(3'h7, 1'b1, 32'h400);
        wb_xfer(1'b1, OFS_CFG, 4'h1, 32'h0, q);
        // Status mask routes the event while the flag interrupt is off
        wb_xfer(1'b1, OFS_MASK, 4'h1, 32'h1, q);
        restart(3'h7, 1'b0);
        wait_irq(1'b1, 200);
        chk_val(edge_cnt, 32'h4);
        wb_xfer(1'b0, OFS_EVT, 4'h1, 32'h0, q);
        chk_val(q, 32'h1);
        repeat (3) @(posedge clk_i);
        chk_bit(irq_o, 1'b0);
        wb_xfer(1'b1, OFS_CTRL, 4'h1, ctrl_w(1'b1, 3'h7, 1'b1, 1'b0), q);
        repeat (3) @(posedge clk_i);
        chk_bit(irq_o, 1'b1);
        wb_xfer(1'b1, OFS_MASK, 4'h1, 32'h0, q);
        // Stop mode with the oscillator kept running: periodic wakeups
        stop <= 1'b1;
        wb_xfer(1'b1, OFS_CFG, 4'h1, 32'h2, q);
        restart(3'h7, 1'b0);
        wait_edges(32'd80);
        chk_val(n_wake - w0, 32'd10);
        chk_val(n_irq - i0, 32'h0);
        // Stop mode with the oscillator off: chain frozen
        wb_xfer(1'b1, OFS_CFG, 4'h1, 32'h0, q);
        restart(3'h7, 1'b0);
        wait_edges(32'd40);
        chk_val(n_wake - w0, 32'h0);
        wb_xfer(1'b0, OFS_CTRL, 4'h1, 32'h0, q);
        chk_val(q, 32'h0f);
        tally_and_finish;
    end
    // Watchdog against a hung handshake or a missing event
    initial begin
        repeat (90000) @(posedge clk_i);
        n_fail++;
        tally_and_finish;
    end
endmodule // tb_top
